// ===== logic/drive_input_terminal_decoder.sv
`timescale 1ns/1ps
// How it works
// - Terminal command mode: code 1 runs forward, code 2 runs reverse.
// - External reset clears the fault only on the rising edge of its input.
// - Terminal command mode: codes 4 and 5 request forward and reverse jog.
// - Four multi-speed inputs form a binary index to fifteen preset speeds.
// - Two inputs pick ramp set; unassigned means set 1 unless program run.
// - External fault, open or closed form, trips with its code except in stop.
// - Increase or decrease input ramps the setpoint at the rate; off holds it.
// - Both increase and decrease on leave the setpoint unchanged.
// - Coast-stop input cuts output at once and lets the motor coast.
// - Three-wire mode without a three-wire input raises the parameter fault.
// - In analog mode code 18 picks panel pot when off, second input when on.
// - With manual traverse start, code 20 enables traverse.
// - DC-brake input holds braking in slow decel-stop until it turns off.
// - DC braking duration is ignored while the DC-brake function is in use.
// - Ramp-inhibit input holds present frequency and suspends ramping.
// - External fault, coast or emergency stop end ramp inhibit at once.
// - Source is terminals when setting 0 and input on, or 1 and off.
// - Switching to terminals while running stops unless a terminal run is valid.
// - Counter counts trigger on-to-off edges and is zero while clear is on.
// - Sleep mode 2 and wake input on bring the PID out of sleep.
// - Polarity setting 0: input off is positive action, on is negative.
// - Emergency stop input coasts the motor; output functions are 0 to 20.
// - Up/down rate is held within 0.10 to 99.99 Hz per second.
// - Each input has its own code 0 to 30; code 0 may repeat. Other codes may repeat here too; their levels are ORed.
module drive_input_terminal_decoder
    import term_decoder_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = DEB_CYCLES
) (
    // Clock and reset
    input  wire logic                            clk_i,
    input  wire logic                            rst_i,
    // Terminals and their function codes
    input  wire logic [NUM_INPUTS-1:0]           terminals_i,
    input  wire logic [NUM_INPUTS-1:0][FUNC_W-1:0] func_codes_i,
    // Settings and drive state
    input  wire settings_t                       cfg_i,
    input  wire drive_status_t                   status_i,
    // Decoded actions
    output cmd_t                                 cmd_o,
    output logic [CNT_W-1:0]                     counter_o,
    output logic [15:0]                          setpoint_o,
    output logic [7:0]                           fault_code_o
);

    typedef struct packed {
        cmd_t                  cmd;
        logic [FUNC_COUNT-1:0] fn_prev;
        logic                  term_prev;
        logic [CNT_W-1:0]      counter;
        logic [ACC_W-1:0]      acc;
        logic [15:0]           setpoint;
        logic [7:0]            fault_code;
    } state_t;

    state_t                st_ff;
    state_t                nxt_st;
    logic [NUM_INPUTS-1:0] level;
    logic [FUNC_COUNT-1:0] fn_on;
    logic [FUNC_COUNT-1:0] fn_asg;
    logic                  nc_open;

    for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_deb
        input_debounce #(
            .STABLE_CYCLES(DEBOUNCE_CYCLES)
        ) u_deb (
            .clk_i  (clk_i),
            .rst_i  (rst_i),
            .raw_i  (terminals_i[g]),
            .level_o(level[g])
        );
    end

    // Several inputs may share a function; their levels are ORed
    always_comb begin
        fn_on   = '0;
        fn_asg  = '0;
        nc_open = 1'b0;
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (func_codes_i[i] != 5'h00 && func_codes_i[i] <= FUNC_MAX) begin
                fn_asg[func_codes_i[i]] = 1'b1;
                fn_on[func_codes_i[i]]  = fn_on[func_codes_i[i]] | level[i];
                if (func_codes_i[i] == FN_EXT_NC && !level[i]) begin
                    nc_open = 1'b1;
                end
            end
        end
    end

    logic        cmd_term;
    logic        ext_now;
    logic        up_only;
    logic        dn_only;
    logic [13:0] rate;
    logic [26:0] acc_sum;
    logic        term_run;

    always_comb begin
        cmd_term = fn_on[FN_SRC_SW] | fn_on[FN_SRC_SW2];
        cmd_term = cmd_term ^ cfg_i.cmd_src;
        ext_now  = fn_on[FN_EXT_NO] | nc_open;
        up_only  = fn_on[FN_UP] & ~fn_on[FN_DOWN];
        dn_only  = fn_on[FN_DOWN] & ~fn_on[FN_UP];
        rate     = cfg_i.updown_rate;
        if (rate < RATE_MIN) begin
            rate = RATE_MIN;
        end else if (rate > RATE_MAX) begin
            rate = RATE_MAX;
        end
        acc_sum  = st_ff.acc + 27'(rate);
        term_run = fn_on[FN_FWD] | fn_on[FN_REV] | fn_on[FN_JOG_F] | fn_on[FN_JOG_R];
    end

    always_comb begin
        nxt_st           = st_ff;
        nxt_st.fn_prev   = fn_on;
        nxt_st.term_prev = cmd_term;

        nxt_st.cmd.cmd_from_term = cmd_term;
        nxt_st.cmd.fwd_run = cmd_term & fn_on[FN_FWD];
        nxt_st.cmd.rev_run = cmd_term & fn_on[FN_REV];
        nxt_st.cmd.jog_fwd = cmd_term & fn_on[FN_JOG_F];
        nxt_st.cmd.jog_rev = cmd_term & fn_on[FN_JOG_R];
        nxt_st.cmd.fault_reset = fn_on[FN_RESET] & ~st_ff.fn_prev[FN_RESET];

        nxt_st.cmd.preset_index = fn_on[FN_MS4:FN_MS1];

        if (fn_asg[FN_RAMP1] | fn_asg[FN_RAMP2]) begin
            nxt_st.cmd.ramp_set = {fn_on[FN_RAMP2], fn_on[FN_RAMP1]};
        end else if (status_i.program_run) begin
            nxt_st.cmd.ramp_set = status_i.program_ramp_set;
        end else begin
            nxt_st.cmd.ramp_set = 2'h0;
        end

        // A trip is one pulse at the onset; holding the input does not retrip
        nxt_st.cmd.ext_fault_active = ext_now;
        nxt_st.cmd.ext_trip = ext_now & ~st_ff.cmd.ext_fault_active
                              & ~status_i.normal_stop;
        if (nxt_st.cmd.ext_trip) begin
            nxt_st.fault_code = EXT_FAULT;
        end else if (nxt_st.cmd.fault_reset) begin
            nxt_st.fault_code = 8'h00;
        end

        nxt_st.cmd.coast_stop = fn_on[FN_COAST];
        nxt_st.cmd.estop      = fn_on[FN_ESTOP];

        nxt_st.cmd.param_fault = (cfg_i.run_wiring_mode == WIRE_3W_A
                                  || cfg_i.run_wiring_mode == WIRE_3W_B)
                                 && !fn_asg[FN_3WIRE];

        nxt_st.cmd.second_analog = cfg_i.analog_ref_mode & fn_on[FN_REF_SW];
        nxt_st.cmd.traverse_en   = cfg_i.traverse_manual & fn_on[FN_TRAVERSE];

        // Braking, once begun, ignores frequency and ends only on release
        nxt_st.cmd.dc_hold = fn_on[FN_DC_BRAKE]
                             & (st_ff.cmd.dc_hold
                                | (status_i.decel_stop
                                   & (status_i.out_freq < status_i.dc_start_freq)));
        nxt_st.cmd.dc_time_ignore = fn_asg[FN_DC_BRAKE];

        nxt_st.cmd.ramp_hold = fn_on[FN_INHIBIT]
                               & ~ext_now & ~fn_on[FN_COAST] & ~fn_on[FN_ESTOP];

        nxt_st.cmd.switch_stop = cmd_term & ~st_ff.term_prev
                                 & status_i.running & ~term_run;

        if (fn_on[FN_CNT_CLR]) begin
            nxt_st.counter = '0;
        end else if (st_ff.fn_prev[FN_CNT_TRIG] & ~fn_on[FN_CNT_TRIG]) begin
            nxt_st.counter = st_ff.counter + 16'h0001;
        end

        nxt_st.cmd.pid_wake = (cfg_i.pid_sleep_mode == SLEEP_WAKE)
                              & fn_on[FN_PID_WAKE];
        nxt_st.cmd.pid_negative = ~cfg_i.pid_polarity & fn_on[FN_PID_POL];

        nxt_st.cmd.relay_func = (cfg_i.relay_func > OUT_FN_MAX) ? 5'h00
                                                                 : cfg_i.relay_func;
        nxt_st.cmd.oc_func = (cfg_i.oc_func > OUT_FN_MAX) ? 5'h00
                                                           : cfg_i.oc_func;

        // Fractional accumulator gives 0.01 Hz steps at rate steps per second
        if (up_only | dn_only) begin
            if (acc_sum >= ACC_WRAP) begin
                nxt_st.acc = acc_sum - ACC_WRAP;
                if (up_only && st_ff.setpoint < FREQ_MAX) begin
                    nxt_st.setpoint = st_ff.setpoint + 16'h0001;
                end else if (dn_only && st_ff.setpoint != 16'h0000) begin
                    nxt_st.setpoint = st_ff.setpoint - 16'h0001;
                end
            end else begin
                nxt_st.acc = acc_sum;
            end
        end else begin
            nxt_st.acc = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cmd_o        = st_ff.cmd;
    assign counter_o    = st_ff.counter;
    assign setpoint_o   = st_ff.setpoint;
    assign fault_code_o = st_ff.fault_code;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_reset_rise;
        !fn_on[FN_RESET] ##1 fn_on[FN_RESET];
    endsequence

    sequence s_trig_fall;
        fn_on[FN_CNT_TRIG] ##1 (!fn_on[FN_CNT_TRIG] && !fn_on[FN_CNT_CLR]);
    endsequence

    property p_fwd;
        (cmd_term && fn_on[FN_FWD]) |=> cmd_o.fwd_run;
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward run not issued");

    property p_reset;
        s_reset_rise |=> cmd_o.fault_reset ##1 !cmd_o.fault_reset;
    endproperty
    a_reset: assert property (p_reset) else $error("reset pulse wrong");

    property p_reset_level;
        (fn_on[FN_RESET] && st_ff.fn_prev[FN_RESET]) |=> !cmd_o.fault_reset;
    endproperty
    a_reset_level: assert property (p_reset_level) else $error("reset on level");

    property p_jog;
        !cmd_term |=> !cmd_o.jog_fwd && !cmd_o.jog_rev;
    endproperty
    a_jog: assert property (p_jog) else $error("jog outside terminal mode");

    property p_preset;
        1'b1 |=> cmd_o.preset_index == $past(fn_on[FN_MS4:FN_MS1]);
    endproperty
    a_preset: assert property (p_preset) else $error("preset index mismatch");

    property p_trip;
        (ext_now && !st_ff.cmd.ext_fault_active && !status_i.normal_stop)
            |=> cmd_o.ext_trip && fault_code_o == EXT_FAULT;
    endproperty
    a_trip: assert property (p_trip) else $error("external fault not tripped");

    property p_trip_stop;
        status_i.normal_stop |=> !cmd_o.ext_trip;
    endproperty
    a_trip_stop: assert property (p_trip_stop) else $error("trip during stop");

    property p_both_hold;
        (fn_on[FN_UP] && fn_on[FN_DOWN]) |=> $stable(setpoint_o);
    endproperty
    a_both_hold: assert property (p_both_hold) else $error("setpoint moved");

    property p_param;
        (cfg_i.run_wiring_mode[1] && !fn_asg[FN_3WIRE]) |=> cmd_o.param_fault;
    endproperty
    a_param: assert property (p_param) else $error("missing parameter fault");

    property p_inhibit;
        ext_now |=> !cmd_o.ramp_hold;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit kept on fault");

    property p_count;
        s_trig_fall |=> counter_o == $past(counter_o) + 16'h0001;
    endproperty
    a_count: assert property (p_count) else $error("counter missed edge");

    property p_clear;
        fn_on[FN_CNT_CLR] |=> counter_o == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("counter not cleared");

    property p_coast;
        fn_on[FN_COAST] |=> cmd_o.coast_stop;
    endproperty
    a_coast: assert property (p_coast) else $error("no coast stop");

    property p_estop;
        fn_on[FN_ESTOP] |=> cmd_o.estop;
    endproperty
    a_estop: assert property (p_estop) else $error("no emergency stop");

    property p_src_term;
        (!cfg_i.cmd_src && fn_on[FN_SRC_SW]) |=> cmd_o.cmd_from_term;
    endproperty
    a_src_term: assert property (p_src_term) else $error("source not terminals");

    property p_src_keypad;
        (cfg_i.cmd_src && fn_on[FN_SRC_SW2]) |=> !cmd_o.cmd_from_term;
    endproperty
    a_src_keypad: assert property (p_src_keypad) else $error("source not keypad");

    property p_ref_sw;
        (cfg_i.analog_ref_mode && fn_on[FN_REF_SW]) |=> cmd_o.second_analog;
    endproperty
    a_ref_sw: assert property (p_ref_sw) else $error("reference not switched");

    property p_traverse;
        (cfg_i.traverse_manual && fn_on[FN_TRAVERSE]) |=> cmd_o.traverse_en;
    endproperty
    a_traverse: assert property (p_traverse) else $error("traverse not enabled");

    property p_dc_release;
        !fn_on[FN_DC_BRAKE] |=> !cmd_o.dc_hold;
    endproperty
    a_dc_release: assert property (p_dc_release) else $error("braking kept");

    property p_dc_time;
        fn_asg[FN_DC_BRAKE] |=> cmd_o.dc_time_ignore;
    endproperty
    a_dc_time: assert property (p_dc_time) else $error("braking time used");

    property p_wake;
        (cfg_i.pid_sleep_mode == SLEEP_WAKE && fn_on[FN_PID_WAKE]) |=> cmd_o.pid_wake;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");

    property p_oc_range;
        (cfg_i.oc_func > OUT_FN_MAX) |=> cmd_o.oc_func == 5'h00;
    endproperty
    a_oc_range: assert property (p_oc_range) else $error("output code kept");

    property p_ramp_default;
        !(fn_asg[FN_RAMP1] || fn_asg[FN_RAMP2] || status_i.program_run)
            |=> cmd_o.ramp_set == 2'h0;
    endproperty
    a_ramp_default: assert property (p_ramp_default) else $error("ramp set not 1");

endmodule

// ===== logic/input_debounce.sv
`timescale 1ns/1ps
module input_debounce
    import term_decoder_pkg::*;
#(
    parameter int STABLE_CYCLES = DEB_CYCLES
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Terminal
    input  wire logic raw_i,
    output logic      level_o
);

    typedef struct packed {
        logic [15:0] cnt;
        logic        level;
    } deb_st_t;

    deb_st_t st_ff;
    deb_st_t nxt_st;

    // Level changes only after a full stable run, so one edge per transition
    always_comb begin
        nxt_st = st_ff;
        if (raw_i == st_ff.level) begin
            nxt_st.cnt = 16'h0000;
        end else if (st_ff.cnt >= 16'(STABLE_CYCLES - 1)) begin
            nxt_st.cnt   = 16'h0000;
            nxt_st.level = raw_i;
        end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign level_o = st_ff.level;

endmodule

// ===== logic/term_decoder_pkg.sv
package term_decoder_pkg;

    // Terminal count and function code space
    localparam int          NUM_INPUTS  = 7;
    localparam int          FUNC_W      = 5;
    localparam int          FUNC_COUNT  = 31;
    localparam logic [4:0]  FUNC_MAX    = 5'h1E;

    localparam logic [4:0]  FN_FWD      = 5'h01;
    localparam logic [4:0]  FN_REV      = 5'h02;
    localparam logic [4:0]  FN_RESET    = 5'h03;
    localparam logic [4:0]  FN_JOG_F    = 5'h04;
    localparam logic [4:0]  FN_JOG_R    = 5'h05;
    localparam logic [4:0]  FN_MS1      = 5'h06;
    localparam logic [4:0]  FN_MS4      = 5'h09;
    localparam logic [4:0]  FN_RAMP1    = 5'h0A;
    localparam logic [4:0]  FN_RAMP2    = 5'h0B;
    localparam logic [4:0]  FN_EXT_NO   = 5'h0C;
    localparam logic [4:0]  FN_EXT_NC   = 5'h0D;
    localparam logic [4:0]  FN_UP       = 5'h0E;
    localparam logic [4:0]  FN_DOWN     = 5'h0F;
    localparam logic [4:0]  FN_COAST    = 5'h10;
    localparam logic [4:0]  FN_3WIRE    = 5'h11;
    localparam logic [4:0]  FN_REF_SW   = 5'h12;
    localparam logic [4:0]  FN_TRAVERSE = 5'h14;
    localparam logic [4:0]  FN_DC_BRAKE = 5'h16;
    localparam logic [4:0]  FN_INHIBIT  = 5'h17;
    localparam logic [4:0]  FN_SRC_SW   = 5'h18;
    localparam logic [4:0]  FN_SRC_SW2  = 5'h19;
    localparam logic [4:0]  FN_CNT_TRIG = 5'h1A;
    localparam logic [4:0]  FN_CNT_CLR  = 5'h1B;
    localparam logic [4:0]  FN_PID_WAKE = 5'h1C;
    localparam logic [4:0]  FN_PID_POL  = 5'h1D;
    localparam logic [4:0]  FN_ESTOP    = 5'h1E;

    // Settings encodings
    localparam logic [1:0]  WIRE_3W_A   = 2'h2;
    localparam logic [1:0]  WIRE_3W_B   = 2'h3;
    localparam logic [1:0]  SLEEP_WAKE  = 2'h2;
    localparam logic [4:0]  OUT_FN_MAX  = 5'h14;
    localparam logic [7:0]  EXT_FAULT   = 8'h0B;

    // Up/down rate in 0.01 Hz/s, setpoint in 0.01 Hz
    localparam logic [13:0] RATE_MIN    = 14'h000A;
    localparam logic [13:0] RATE_MAX    = 14'h270F;
    localparam logic [15:0] FREQ_MAX    = 16'h9C40;

    // Timing
    localparam int          CLK_FREQ_HZ = 40_000_000;
    localparam int          DEB_TIME_US = 1000;
    localparam int          DEB_CYCLES  = DEB_TIME_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int          ACC_W       = 27;
    localparam logic [26:0] ACC_WRAP    = 27'(CLK_FREQ_HZ);
    localparam int          CNT_W       = 16;

    typedef struct packed {
        logic        cmd_src;
        logic [1:0]  run_wiring_mode;
        logic        analog_ref_mode;
        logic        traverse_manual;
        logic [1:0]  pid_sleep_mode;
        logic        pid_polarity;
        logic [13:0] updown_rate;
        logic [4:0]  relay_func;
        logic [4:0]  oc_func;
    } settings_t;

    typedef struct packed {
        logic        running;
        logic        normal_stop;
        logic        decel_stop;
        logic        program_run;
        logic [1:0]  program_ramp_set;
        logic [15:0] out_freq;
        logic [15:0] dc_start_freq;
    } drive_status_t;

    typedef struct packed {
        logic        fwd_run;
        logic        rev_run;
        logic        jog_fwd;
        logic        jog_rev;
        logic        fault_reset;
        logic [3:0]  preset_index;
        logic [1:0]  ramp_set;
        logic        ext_fault_active;
        logic        ext_trip;
        logic        coast_stop;
        logic        param_fault;
        logic        second_analog;
        logic        traverse_en;
        logic        dc_hold;
        logic        dc_time_ignore;
        logic        ramp_hold;
        logic        cmd_from_term;
        logic        switch_stop;
        logic        pid_wake;
        logic        pid_negative;
        logic        estop;
        logic [4:0]  relay_func;
        logic [4:0]  oc_func;
    } cmd_t;

endpackage

// ===== test/drive_input_terminal_decoder_bench.sv
`timescale 1ns/1ps
module drive_input_terminal_decoder_bench;
    import term_decoder_pkg::*;

    // Short debounce keeps the run small; waits derive from it
    localparam int DEB    = 3;
    localparam int SETTLE = DEB + 8;

    logic                              clk_i       = 1'b0;
    logic                              rst_i       = 1'b1;
    logic [NUM_INPUTS-1:0]             want        = '0;
    logic [NUM_INPUTS-1:0]             terminals;
    logic [NUM_INPUTS-1:0][FUNC_W-1:0] codes       = '0;
    settings_t                         cfg         = '0;
    drive_status_t                     st          = '0;
    cmd_t                              cmd;
    cmd_t                              e;
    logic [CNT_W-1:0]                  counter;
    logic [15:0]                       setpoint;
    logic [7:0]                        fault_code;
    int                                miscompares = 0;
    int                                comparisons = 0;
    int                                trips       = 0;
    int                                resets      = 0;
    int                                stops       = 0;

    always #12.5 clk_i = ~clk_i;

    switch_bank contacts (.clk_i(clk_i), .want_i(want), .terminals_o(terminals));

    drive_input_terminal_decoder #(.DEBOUNCE_CYCLES(DEB)) DUT (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .terminals_i  (terminals),
        .func_codes_i (codes),
        .cfg_i        (cfg),
        .status_i     (st),
        .cmd_o        (cmd),
        .counter_o    (counter),
        .setpoint_o   (setpoint),
        .fault_code_o (fault_code)
    );

    // Pulses last one cycle, so count them as they pass
    always @(posedge clk_i) begin
        if (cmd.ext_trip === 1'b1) trips <= trips + 1;
        if (cmd.fault_reset === 1'b1) resets <= resets + 1;
        if (cmd.switch_stop === 1'b1) stops <= stops + 1;
    end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic press(input logic [NUM_INPUTS-1:0] w);
        @(posedge clk_i);
        want <= w;
        settle(SETTLE);
    endtask

    // Release contacts before recoding, so stale levels never meet new codes
    task automatic setup(input logic [4:0] c0, input logic [4:0] c1,
                         input logic [4:0] c2, input logic [4:0] c3);
        press('0);
        @(posedge clk_i);
        codes <= {15'h0, c3, c2, c1, c0};
        cfg   <= '0;
        st    <= '0;
        settle(SETTLE);
        e = '0;
    endtask

    task automatic t_run();
        setup(FN_FWD, FN_REV, FN_JOG_F, FN_JOG_R);
        @(posedge clk_i);
        codes[4] <= FN_SRC_SW;
        press(7'h0F);
        check("keypad", 64'(cmd), 64'(e));
        press(7'h1F);
        e = '{fwd_run: 1'b1, rev_run: 1'b1, jog_fwd: 1'b1, jog_rev: 1'b1,
              cmd_from_term: 1'b1, default: 0};
        check("terminal", 64'(cmd), 64'(e));
        press(7'h00);
        @(posedge clk_i);
        st.running <= 1'b1;
        press(7'h10);
        press(7'h00);
        press(7'h11);
        check("switch stop", 64'(stops), 64'h1);
        @(posedge clk_i);
        st.running  <= 1'b0;
        cfg.cmd_src <= 1'b1;
        codes[4]    <= FN_SRC_SW2;
        press(7'h01);
        e = '{fwd_run: 1'b1, cmd_from_term: 1'b1, default: 0};
        check("source 1", 64'(cmd), 64'(e));
    endtask

    task automatic t_speed_ramp();
        setup(FN_MS1, 5'h07, 5'h08, FN_MS4);
        for (int i = 0; i < 16; i++) begin
            press(7'(i));
            e.preset_index = 4'(i);
            check("preset", 64'(cmd), 64'(e));
        end
        setup(FN_RAMP1, FN_RAMP2, 5'h00, 5'h00);
        for (int i = 0; i < 4; i++) begin
            press(7'(i));
            e.ramp_set = 2'(i);
            check("ramp set", 64'(cmd), 64'(e));
        end
        setup(5'h00, 5'h00, 5'h00, 5'h00);
        check("ramp default", 64'(cmd.ramp_set), 64'h0);
        @(posedge clk_i);
        st.program_run      <= 1'b1;
        st.program_ramp_set <= 2'h3;
        settle(SETTLE);
        check("ramp program", 64'(cmd.ramp_set), 64'h3);
    endtask

    task automatic t_fault();
        setup(FN_EXT_NO, FN_RESET, FN_INHIBIT, 5'h00);
        @(posedge clk_i);
        st.normal_stop <= 1'b1;
        press(7'h01);
        check("stop trip", 64'({trips, fault_code}), 64'h0);
        press(7'h00);
        @(posedge clk_i);
        st.normal_stop <= 1'b0;
        press(7'h04);
        check("inhibit", 64'(cmd.ramp_hold), 64'h1);
        press(7'h05);
        check("trip", 64'({trips, fault_code}), 64'({32'h1, EXT_FAULT}));
        check("inhibit end", 64'(cmd.ramp_hold), 64'h0);
        press(7'h06);
        settle(SETTLE);
        check("reset", 64'({resets, fault_code}), 64'h100);
        setup(FN_EXT_NC, 5'h00, 5'h00, 5'h00);
        check("closed form", 64'({trips, fault_code}), 64'({32'h2, EXT_FAULT}));
    endtask

    task automatic t_stop_count();
        setup(FN_INHIBIT, FN_COAST, FN_ESTOP, 5'h00);
        press(7'h01);
        e = '{ramp_hold: 1'b1, default: 0};
        check("hold", 64'(cmd), 64'(e));
        press(7'h03);
        e = '{coast_stop: 1'b1, default: 0};
        check("coast", 64'(cmd), 64'(e));
        press(7'h05);
        e = '{estop: 1'b1, default: 0};
        check("estop", 64'(cmd), 64'(e));
        setup(FN_CNT_TRIG, FN_CNT_CLR, 5'h00, 5'h00);
        repeat (3) begin
            press(7'h01);
            press(7'h00);
        end
        check("count", 64'(counter), 64'h3);
        press(7'h02);
        press(7'h03);
        press(7'h02);
        check("clear", 64'(counter), 64'h0);
    endtask

    // Rate above range clamps to 9999: one step per 40e6/9999 cycles
    task automatic t_updown();
        setup(FN_UP, FN_DOWN, 5'h00, 5'h00);
        @(posedge clk_i);
        cfg.updown_rate <= 14'h3FFF;
        press(7'h01);
        settle(8500);
        check("up", 64'(setpoint), 64'h2);
        press(7'h03);
        settle(4100);
        check("both", 64'(setpoint), 64'h2);
        press(7'h02);
        settle(4100);
        check("down", 64'(setpoint), 64'h1);
        press(7'h00);
        settle(4100);
        check("idle", 64'(setpoint), 64'h1);
    endtask

    task automatic t_misc();
        setup(5'h00, 5'h00, 5'h00, 5'h00);
        @(posedge clk_i);
        cfg.run_wiring_mode <= WIRE_3W_A;
        settle(SETTLE);
        e = '{param_fault: 1'b1, default: 0};
        check("wiring 2", 64'(cmd), 64'(e));
        @(posedge clk_i);
        cfg.run_wiring_mode <= WIRE_3W_B;
        settle(SETTLE);
        check("wiring 3", 64'(cmd), 64'(e));
        @(posedge clk_i);
        codes[6] <= FN_3WIRE;
        settle(SETTLE);
        check("wiring ok", 64'(cmd.param_fault), 64'h0);
        setup(FN_REF_SW, FN_TRAVERSE, FN_PID_WAKE, FN_PID_POL);
        @(posedge clk_i);
        codes[4]            <= 5'h1F;
        cfg.analog_ref_mode <= 1'b1;
        cfg.traverse_manual <= 1'b1;
        cfg.pid_sleep_mode  <= SLEEP_WAKE;
        cfg.relay_func      <= OUT_FN_MAX;
        cfg.oc_func         <= 5'h15;
        press(7'h1F);
        e = '{second_analog: 1'b1, traverse_en: 1'b1, pid_wake: 1'b1, pid_negative: 1'b1,
              relay_func: OUT_FN_MAX, default: 0};
        check("gated on", 64'(cmd), 64'(e));
        @(posedge clk_i);
        cfg.analog_ref_mode <= 1'b0;
        cfg.traverse_manual <= 1'b0;
        cfg.pid_sleep_mode  <= 2'h1;
        cfg.pid_polarity    <= 1'b1;
        settle(SETTLE);
        e = '{relay_func: OUT_FN_MAX, default: 0};
        check("gated off", 64'(cmd), 64'(e));
        setup(FN_DC_BRAKE, 5'h00, 5'h00, 5'h00);
        @(posedge clk_i);
        st.decel_stop    <= 1'b1;
        st.out_freq      <= 16'h0064;
        st.dc_start_freq <= 16'h00C8;
        press(7'h01);
        check("dc on", 64'({cmd.dc_hold, cmd.dc_time_ignore}), 64'h3);
        @(posedge clk_i);
        st.out_freq <= 16'h012C;
        settle(SETTLE);
        check("dc held", 64'(cmd.dc_hold), 64'h1);
        press(7'h00);
        check("dc off", 64'(cmd.dc_hold), 64'h0);
    endtask

    task automatic results();
        if (miscompares == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        settle(2);
        check("reset", 64'({counter, setpoint, fault_code}), 64'h0);
        check("reset cmd", 64'(cmd), 64'h0);
        t_run();
        t_speed_ramp();
        t_fault();
        t_stop_count();
        t_updown();
        t_misc();
        results();
    end

    // Whole run needs about 22000 cycles
    initial begin
        repeat (60000) @(posedge clk_i);
        miscompares++;
        results();
    end
endmodule

// ===== test/switch_bank.sv
`timescale 1ns/1ps
module switch_bank
    import term_decoder_pkg::*;
(
    // Clock and wanted contact states
    input  wire logic                  clk_i,
    input  wire logic [NUM_INPUTS-1:0] want_i,
    // Terminal levels seen by the drive
    output logic      [NUM_INPUTS-1:0] terminals_o
);
    logic [NUM_INPUTS-1:0] last_ff  = '0;
    logic [1:0]            phase_ff = 2'h0;

    // Contacts chatter: every change is followed by a one-cycle glitch on all lines
    always @(posedge clk_i) begin
        if (want_i !== last_ff) begin
            last_ff     <= want_i;
            terminals_o <= want_i;
            phase_ff    <= 2'h1;
        end else if (phase_ff == 2'h1) begin
            terminals_o <= ~want_i;
            phase_ff    <= 2'h2;
        end else begin
            terminals_o <= want_i;
            phase_ff    <= 2'h0;
        end
    end
endmodule
